// ---- dv/sacc_analog_model.sv ----
`timescale 1ns/1ps
// Far side of the converter: pins and on-chip sources seen through the comparator.
// Each source is either at full scale or at ground, so the comparator answer is fixed per channel except on reserved channels 22 to 25.
module sacc_analog_model (
	input  wire logic        core_clk,
	input  wire logic [27:0] mux_sel,
	input  wire logic [27:0] high_mask,
	output logic             comp_in
);
	localparam logic [27:0] VSS_MASK = 28'h00FFF00; // Channels 8 to 19 sit on ground.
	localparam logic [27:0] RSV_MASK = 28'h3C00000; // Channels 22 to 25 lead nowhere.
	logic toggle_r; // Changes every cycle so a floating input never reads as a clean level.

	// Free-running pattern for unselected or reserved inputs.
	initial toggle_r = 1'b0;
	always @(posedge core_clk) toggle_r <= ~toggle_r;

	// A high source keeps every trial bit, a grounded one drops every trial bit.
	always_comb begin
		if (|(mux_sel & high_mask & ~VSS_MASK & ~RSV_MASK)) begin
			comp_in = 1'b0;
		end else if (|(mux_sel & ~RSV_MASK)) begin
			comp_in = 1'b1;
		end else begin
			comp_in = toggle_r;
		end
	end
endmodule

// ---- dv/tb_sacc_top.sv ----
`timescale 1ns/1ps
// Register-level bench for the converter control block.
module tb_sacc_top;
	logic        core_clk = 1'b0;  // Bus clock.
	logic        reset = 1'b1;     // Asynchronous reset.
	logic [3:0]  reg_addr = 4'h0;  // Register index.
	logic [7:0]  reg_wdata = 8'h00;// Write data.
	logic        reg_wr = 1'b0;    // Write strobe.
	logic        reg_rd = 1'b0;    // Read strobe.
	logic [7:0]  reg_rdata;        // Read data.
	logic        stop_mode = 1'b0; // Stop mode level.
	logic        comp_in;          // Comparator answer.
	logic [27:0] mux_sel;          // One-hot channel select.
	logic [7:0]  pin_analog;       // Pins in analog use.
	logic        dac_bit_set;      // Approximation running.
	logic        sample_on;        // Sampling running.
	logic        conv_irq;         // Interrupt level.
	logic        alternate_clock_input; // Must stay low.
	logic [27:0] high_mask = 28'h0;// Sources at full scale.
	int          bad_count = 0;    // Mismatches.
	int          checked = 0;      // Comparisons.
	int          cycles = 0;       // Watchdog count.
	logic [7:0]  d;                // Last read value.
	logic [1:0]  clks [3] = '{2'h0, 2'h1, 2'h3}; // The three offered clock choices.

	always #12.5 core_clk = ~core_clk;

	sacc_top #(.LOCAL_DIV(4)) i_sacc_top (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.stop_mode(stop_mode), .comp_in(comp_in), .mux_sel(mux_sel), .pin_analog(pin_analog),
		.dac_bit_set(dac_bit_set), .sample_on(sample_on), .conv_irq(conv_irq),
		.alternate_clock_input(alternate_clock_input));

	sacc_analog_model i_sacc_analog_model (.core_clk(core_clk), .mux_sel(mux_sel),
		.high_mask(high_mask), .comp_in(comp_in));

	// One write cycle; the strobe drops at the next edge.
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	// One read cycle; the data stand in the following cycle only.
	task automatic rd(input logic [3:0] a);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		d = reg_rdata;
	endtask

	// Compares any register or port value.
	task automatic chk(input string name, input logic [27:0] exp, input logic [27:0] got);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Polls the done flag with a bound; a hang counts as a mismatch.
	task automatic wait_done();
		int n;
		n = 0;
		rd(sacc_pkg::OFF_SC1);
		while (d[sacc_pkg::SC1_DONE_BIT] !== 1'b1 && n < 300) begin
			rd(sacc_pkg::OFF_SC1);
			n++;
		end
		chk("done_flag", 28'h1, {27'h0, d[sacc_pkg::SC1_DONE_BIT]});
	endtask

	// Reads both result bytes, high first so the pair stays together.
	task automatic chk_res(input logic [7:0] hi, input logic [7:0] lo);
		rd(sacc_pkg::OFF_RES_HI);
		chk("res_hi", {20'h0, hi}, {20'h0, d});
		rd(sacc_pkg::OFF_RES_LO);
		chk("res_lo", {20'h0, lo}, {20'h0, d});
	endtask

	task automatic final_report();
		$display("checked %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Cuts a hang short well above the expected run length.
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			bad_count++;
			final_report();
		end
	end

	initial begin
		repeat (10) @(posedge core_clk);
		reset <= 1'b0;
		rd(sacc_pkg::OFF_SC1);
		chk("sc1_reset", 28'h1F, {20'h0, d});
		chk("alt_clk", 28'h0, {27'h0, alternate_clock_input});
		chk("mux_reset", 28'h0, mux_sel);
		rd(4'hF);
		chk("unmapped", 28'h0, {20'h0, d});
		wr(sacc_pkg::OFF_PIN, 8'hA5);
		rd(sacc_pkg::OFF_PIN);
		chk("pin_reg", 28'hA5, {20'h0, d});
		chk("pin_analog", 28'hA5, {20'h0, pin_analog});
		wr(sacc_pkg::OFF_CFG, 8'h06);
		rd(sacc_pkg::OFF_CFG);
		chk("cfg_alt", 28'h04, {20'h0, d});
		// Every channel code reaches its own select line; codes above 27 reach none.
		for (int c = 0; c < 32; c++) begin
			wr(sacc_pkg::OFF_SC1, 8'(c));
			repeat (2) @(posedge core_clk);
			@(negedge core_clk);
			chk("mux_sel", (c < 28) ? (28'h1 << c) : 28'h0, mux_sel);
		end
		// Single 10-bit conversion on a high pin, under each clock choice.
		high_mask = 28'hC00_0008;
		foreach (clks[i]) begin
			wr(sacc_pkg::OFF_CFG, {6'h01, clks[i]});
			wr(sacc_pkg::OFF_SC1, 8'h43);
			wait_done();
			chk("irq", 28'h1, {27'h0, conv_irq});
			chk_res(8'h03, 8'hFF);
			rd(sacc_pkg::OFF_SC1);
			chk("done_clr", 28'h0, {27'h0, d[7]});
			rd(sacc_pkg::OFF_SC2);
			chk("idle", 28'h0, {27'h0, d[7]});
		end
		// 8-bit conversion of a grounded channel, and long sample on the temperature sensor.
		wr(sacc_pkg::OFF_CFG, 8'h00);
		wr(sacc_pkg::OFF_SC1, 8'h09);
		wait_done();
		chk_res(8'h00, 8'h00);
		wr(sacc_pkg::OFF_CFG, 8'h13);
		wr(sacc_pkg::OFF_SC1, {3'h0, sacc_pkg::CH_TEMP});
		wait_done();
		chk("irq_off", 28'h0, {27'h0, conv_irq});
		chk_res(8'h00, 8'hFF);
		// Compare: greater-or-equal holds on a high input and fails on a low one.
		wr(sacc_pkg::OFF_CFG, 8'h00);
		wr(sacc_pkg::OFF_CMP_LO, 8'h80);
		wr(sacc_pkg::OFF_SC2, 8'h30);
		wr(sacc_pkg::OFF_SC1, 8'h03);
		wait_done();
		chk_res(8'h00, 8'hFF);
		wr(sacc_pkg::OFF_SC1, 8'h08);
		repeat (200) @(posedge core_clk);
		rd(sacc_pkg::OFF_SC1);
		chk("cmp_false", 28'h0, {27'h0, d[7]});
		wr(sacc_pkg::OFF_SC2, 8'h20);
		wr(sacc_pkg::OFF_SC1, 8'h08);
		wait_done();
		wr(sacc_pkg::OFF_SC2, 8'h00);
		// Continuous run, restarted by a write, then stopped by the all-ones code.
		wr(sacc_pkg::OFF_SC1, 8'h63);
		wait_done();
		wr(sacc_pkg::OFF_SC1, 8'h63);
		rd(sacc_pkg::OFF_SC1);
		chk("wr_clr", 28'h0, {27'h0, d[7]});
		wait_done();
		wr(sacc_pkg::OFF_SC1, 8'h3F);
		repeat (200) @(posedge core_clk);
		rd(sacc_pkg::OFF_SC1);
		chk("off_done", 28'h0, {27'h0, d[7]});
		rd(sacc_pkg::OFF_SC2);
		chk("off_act", 28'h0, {27'h0, d[7]});
		// Stop mode pauses conversion until both low-voltage enables are set.
		@(posedge core_clk);
		stop_mode <= 1'b1;
		wr(sacc_pkg::OFF_PWR, 8'h04);
		wr(sacc_pkg::OFF_SC1, 8'h03);
		repeat (200) @(posedge core_clk);
		rd(sacc_pkg::OFF_SC1);
		chk("stop_hold", 28'h0, {27'h0, d[7]});
		chk("stop_samp", 28'h1, {27'h0, sample_on});
		chk("stop_dac", 28'h0, {27'h0, dac_bit_set});
		wr(sacc_pkg::OFF_PWR, 8'h06);
		wait_done();
		chk("end_samp", 28'h0, {27'h0, sample_on});
		chk("end_dac", 28'h0, {27'h0, dac_bit_set});
		@(posedge core_clk);
		stop_mode <= 1'b0;
		chk("alt_clk_end", 28'h0, {27'h0, alternate_clock_input});
		final_report();
	end
endmodule

// ---- verilog/sacc_chan_map.sv ----
`timescale 1ns/1ps
// Decodes the channel select field into analog mux selects and pin routing.
module sacc_chan_map (
	input  wire logic [4:0]  chan,
	input  wire logic [7:0]  pin_en,
	output logic [27:0]      mux_sel,
	output logic             reserved,
	output logic [7:0]       pin_analog
);
	// One mux select per channel; codes above 27 select none of the inputs.
	for (genvar i = 0; i < 28; i++) begin : g_sel
		assign mux_sel[i] = (chan == 5'(i));
	end

	// Pin-connected channels take their routing from their own pin control bit.
	assign pin_analog = pin_en;

	// Reserved codes still convert but yield an undefined value.
	assign reserved = (chan >= 5'h16 && chan <= 5'h19) || chan == 5'h1C;
endmodule

// ---- verilog/sacc_pkg.sv ----
package sacc_pkg;
	// Register offsets on the plain register port.
	localparam logic [3:0] OFF_SC1    = 4'h0; // First status and control register.
	localparam logic [3:0] OFF_SC2    = 4'h1; // Second status and control register.
	localparam logic [3:0] OFF_RES_HI = 4'h2; // Result upper two bits.
	localparam logic [3:0] OFF_RES_LO = 4'h3; // Result low byte.
	localparam logic [3:0] OFF_CMP_HI = 4'h4; // Compare value upper two bits.
	localparam logic [3:0] OFF_CMP_LO = 4'h5; // Compare value low byte.
	localparam logic [3:0] OFF_CFG    = 4'h6; // Configuration register.
	localparam logic [3:0] OFF_PIN    = 4'h7; // Pin enable register one.
	localparam logic [3:0] OFF_PWR    = 4'h8; // Power management status and control.
	// Field positions.
	localparam int SC1_DONE_BIT = 7; // Conversion done flag.
	localparam int SC1_IEN_BIT  = 6; // Interrupt enable.
	localparam int SC1_CONT_BIT = 5; // Continuous conversion.
	localparam int SC2_ACT_BIT  = 7; // Conversion active.
	localparam int SC2_CMPE_BIT = 5; // Compare enable.
	localparam int SC2_CMGE_BIT = 4; // Compare greater or equal select.
	localparam int CFG_MODE_BIT = 2; // Resolution: one selects 10 bits.
	localparam int PWR_LOWVOLT_DETECT_ENABLE_BIT = 2; // Low-voltage detect enable.
	localparam int PWR_LVSE_BIT = 1; // Low-voltage stop enable.
	// Channel codes.
	localparam logic [4:0] CH_PIN_LAST = 5'h07; // Last pin-connected channel.
	localparam logic [4:0] CH_PRG2     = 5'h14; // Second reference generator output.
	localparam logic [4:0] CH_PRG1     = 5'h15; // First reference generator output.
	localparam logic [4:0] CH_TEMP     = 5'h1A; // Temperature sensor.
	localparam logic [4:0] CH_BGAP     = 5'h1B; // Internal bandgap.
	localparam logic [4:0] CH_OFF      = 5'h1F; // All ones: subsystem off.
	// Clock choices in the configuration register.
	localparam logic [1:0] CLK_BUS     = 2'h0; // Bus clock.
	localparam logic [1:0] CLK_BUS_DIV = 2'h1; // Bus clock divided by two.
	localparam logic [1:0] CLK_ALT     = 2'h2; // Alternate clock, not offered.
	localparam logic [1:0] CLK_LOCAL   = 2'h3; // Local asynchronous clock.
	localparam int CONV_STEPS = 10; // Successive approximation steps.
	localparam int SAMPLE_SHORT = 4; // Short sample phase in conversion ticks.
	localparam int SAMPLE_LONG  = 20; // Long sample phase in conversion ticks.
	localparam logic [7:0] RESET_SC1 = 8'h1F; // Channel field all ones at reset.
	typedef enum logic [1:0] {
		SACC_IDLE,
		SACC_SAMPLE,
		SACC_CONVERT
	} sacc_state_e;
endpackage

// ---- verilog/sacc_tick_gen.sv ----
`timescale 1ns/1ps
// Makes the conversion clock tick from the bus clock, the halved bus clock or a local divider.
module sacc_tick_gen #(
	parameter int LOCAL_DIV = 4 // Divider that stands in for the local asynchronous clock.
) (
	input  wire logic       core_clk,
	input  wire logic       reset,
	input  wire logic       run,
	input  wire logic [1:0] clk_sel,
	output logic            tick
);
	typedef struct packed {
		logic       half;  // Toggles for the halved bus clock.
		logic [7:0] cnt;   // Local divider count.
		logic       tick;  // Registered tick.
	} sacc_tick_s;
	sacc_tick_s st_r, st_nxt;

	// Choose the tick source; the alternate choice never ticks because its input is held low.
	always_comb begin
		st_nxt = st_r;
		st_nxt.tick = 1'b0;
		if (!run) begin
			st_nxt.half = 1'b0;
			st_nxt.cnt = 8'h00;
		end else begin
			unique case (clk_sel)
				sacc_pkg::CLK_BUS: begin
					st_nxt.tick = 1'b1;
				end
				sacc_pkg::CLK_BUS_DIV: begin
					st_nxt.half = ~st_r.half;
					st_nxt.tick = st_r.half;
				end
				sacc_pkg::CLK_ALT: begin
					st_nxt.tick = 1'b0;
				end
				sacc_pkg::CLK_LOCAL: begin
					if (st_r.cnt == 8'(LOCAL_DIV - 1)) begin
						st_nxt.cnt = 8'h00;
						st_nxt.tick = 1'b1;
					end else begin
						st_nxt.cnt = st_r.cnt + 8'h01;
					end
				end
			endcase
		end
	end

	// Register the state.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign tick = st_r.tick;
endmodule

// ---- verilog/sacc_top.sv ----
`timescale 1ns/1ps
module sacc_top #(
	parameter int LOCAL_DIV = 4 // Local clock divider.
) (
	input  wire logic        core_clk,
	input  wire logic        reset,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [7:0]       reg_rdata,
	input  wire logic        stop_mode,
	input  wire logic        comp_in,
	output logic [27:0]      mux_sel,
	output logic [7:0]       pin_analog,
	output logic             dac_bit_set,
	output logic             sample_on,
	output logic             conv_irq,
	output logic             alternate_clock_input
);
	typedef struct packed {
		logic [7:0]  sc1;        // Interrupt enable, continuous, channel; bit 7 unused here.
		logic        done;       // Conversion done flag.
		logic        cmp_en;     // Compare enable.
		logic        cmp_ge;     // Compare greater or equal select.
		logic [9:0]  cmp_val;    // Compare value.
		logic [7:0]  cfg;        // Configuration.
		logic [7:0]  pin_en;     // Pin enable register one.
		logic [7:0]  pwr;        // Power management bits.
		logic [9:0]  result;     // Result register.
		logic [9:0]  sar;        // Approximation register.
		logic [4:0]  step;       // Remaining steps or sample ticks.
		logic        hi_lock;    // High byte read, results held.
		sacc_pkg::sacc_state_e state;
		logic [7:0]  rdata;      // Read data.
		logic [27:0] mux;        // Registered mux selects.
		logic [7:0]  pin_a;      // Registered pin routing.
		logic        dac;        // Trial bit to the analog comparator.
		logic        samp;       // Sample switch.
		logic        irq;        // Interrupt out.
	} sacc_top_s;
	sacc_top_s st_r, st_nxt;

	logic        tick;      // Conversion clock tick.
	logic [27:0] sel_w;     // Decoded mux selects.
	logic        res_w;     // Reserved code seen.
	logic [7:0]  pin_w;     // Decoded pin routing.
	logic        run_ok;    // Converter may run in this power state.
	logic        ten_bit;   // Resolution select.
	logic [9:0]  trial;     // Trial value under test.
	logic [9:0]  final_v;   // Finished value.
	logic        cmp_true;  // Compare outcome.
	logic        wr_sc1;    // Write to first status register.

	assign ten_bit = st_r.cfg[sacc_pkg::CFG_MODE_BIT];
	// In stop mode both low-voltage bits must be set; wait is not gated at all.
	assign run_ok = !stop_mode ||
		(st_r.pwr[sacc_pkg::PWR_LOWVOLT_DETECT_ENABLE_BIT] && st_r.pwr[sacc_pkg::PWR_LVSE_BIT]);
	assign wr_sc1 = reg_wr && reg_addr == sacc_pkg::OFF_SC1;

	sacc_tick_gen #(
		.LOCAL_DIV(LOCAL_DIV)
	) u_tick (
		.core_clk(core_clk),
		.reset   (reset),
		.run     (st_r.state != sacc_pkg::SACC_IDLE),
		.clk_sel (st_r.cfg[1:0]),
		.tick    (tick)
	);

	sacc_chan_map u_map (
		.chan      (st_r.sc1[4:0]),
		.pin_en    (st_r.pin_en),
		.mux_sel   (sel_w),
		.reserved  (res_w),
		.pin_analog(pin_w)
	);

	// Trial value: the bit under test set onto what is already kept.
	assign trial = st_r.sar | (10'h001 << st_r.step);
	// A reserved channel's result is undefined; the approximation simply runs on.
	assign final_v = comp_in ? st_r.sar : trial;
	// Compare: 8-bit mode looks only at the low byte.
	always_comb begin
		logic lt;
		lt = 1'b0;
		if (ten_bit) begin
			lt = final_v < st_r.cmp_val;
		end else begin
			lt = final_v[7:0] < st_r.cmp_val[7:0];
		end
		cmp_true = st_r.cmp_ge ? !lt : lt;
	end

	// Main next-state process: register port, conversion sequencing and flag handling.
	always_comb begin
		st_nxt = st_r;
		st_nxt.rdata = 8'h00;
		st_nxt.mux = sel_w;
		st_nxt.pin_a = pin_w;
		// Register writes.
		if (reg_wr) begin
			unique case (reg_addr)
				sacc_pkg::OFF_SC1: st_nxt.sc1 = {1'b0, reg_wdata[6:0]};
				sacc_pkg::OFF_SC2: begin
					st_nxt.cmp_en = reg_wdata[sacc_pkg::SC2_CMPE_BIT];
					st_nxt.cmp_ge = reg_wdata[sacc_pkg::SC2_CMGE_BIT];
				end
				sacc_pkg::OFF_CMP_HI: st_nxt.cmp_val[9:8] = reg_wdata[1:0];
				sacc_pkg::OFF_CMP_LO: st_nxt.cmp_val[7:0] = reg_wdata;
				// The alternate clock is not offered: that choice falls back to the bus clock.
				sacc_pkg::OFF_CFG: begin
					st_nxt.cfg = reg_wdata;
					if (reg_wdata[1:0] == sacc_pkg::CLK_ALT) begin
						st_nxt.cfg[1:0] = sacc_pkg::CLK_BUS;
					end
				end
				sacc_pkg::OFF_PIN: st_nxt.pin_en = reg_wdata;
				sacc_pkg::OFF_PWR: st_nxt.pwr = reg_wdata;
				default: ;
			endcase
		end
		// Reads: data stand one cycle later.
		if (reg_rd) begin
			unique case (reg_addr)
				sacc_pkg::OFF_SC1: st_nxt.rdata = {st_r.done, st_r.sc1[6:0]};
				sacc_pkg::OFF_SC2: st_nxt.rdata = {st_r.state != sacc_pkg::SACC_IDLE, 1'b0,
					st_r.cmp_en, st_r.cmp_ge, 4'h0};
				sacc_pkg::OFF_RES_HI: begin
					st_nxt.rdata = {6'h00, st_r.result[9:8]};
					st_nxt.hi_lock = ten_bit;
				end
				sacc_pkg::OFF_RES_LO: begin
					st_nxt.rdata = st_r.result[7:0];
					st_nxt.hi_lock = 1'b0;
					st_nxt.done = 1'b0;
				end
				sacc_pkg::OFF_CMP_HI: st_nxt.rdata = {6'h00, st_r.cmp_val[9:8]};
				sacc_pkg::OFF_CMP_LO: st_nxt.rdata = st_r.cmp_val[7:0];
				sacc_pkg::OFF_CFG: st_nxt.rdata = st_r.cfg;
				sacc_pkg::OFF_PIN: st_nxt.rdata = st_r.pin_en;
				sacc_pkg::OFF_PWR: st_nxt.rdata = st_r.pwr;
				default: st_nxt.rdata = 8'h00;
			endcase
		end
		// Conversion sequencing; paused while stop mode forbids running.
		if (run_ok && tick) begin
			unique case (st_r.state)
				sacc_pkg::SACC_IDLE: ;
				sacc_pkg::SACC_SAMPLE: begin
					if (st_r.step == 5'h00) begin
						st_nxt.state = sacc_pkg::SACC_CONVERT;
						st_nxt.samp = 1'b0;
						st_nxt.sar = 10'h000;
						st_nxt.step = ten_bit ? 5'(sacc_pkg::CONV_STEPS - 1) : 5'(7);
					end else begin
						st_nxt.step = st_r.step - 5'h01;
					end
				end
				sacc_pkg::SACC_CONVERT: begin
					st_nxt.sar = final_v;
					if (st_r.step == 5'h00) begin
						// Set wins over a low-byte read clear in the same cycle.
						if (!st_r.cmp_en || cmp_true) begin
							st_nxt.done = 1'b1;
							if (!st_r.hi_lock) begin
								st_nxt.result = ten_bit ? final_v : {2'b00, final_v[7:0]};
							end
						end
						if (st_r.sc1[sacc_pkg::SC1_CONT_BIT]) begin
							st_nxt.state = sacc_pkg::SACC_SAMPLE;
							st_nxt.samp = 1'b1;
							st_nxt.step = st_r.cfg[4] ? 5'(sacc_pkg::SAMPLE_LONG) : 5'(sacc_pkg::SAMPLE_SHORT);
						end else begin
							st_nxt.state = sacc_pkg::SACC_IDLE;
						end
					end else begin
						st_nxt.step = st_r.step - 5'h01;
					end
				end
			endcase
		end
		st_nxt.dac = (st_nxt.state == sacc_pkg::SACC_CONVERT);
		// A write to the first register aborts and restarts, unless the channel is all ones.
		if (wr_sc1) begin
			st_nxt.done = 1'b0;
			if (reg_wdata[4:0] == sacc_pkg::CH_OFF) begin
				st_nxt.state = sacc_pkg::SACC_IDLE;
				st_nxt.samp = 1'b0;
				st_nxt.dac = 1'b0;
			end else begin
				st_nxt.state = sacc_pkg::SACC_SAMPLE;
				st_nxt.samp = 1'b1;
				st_nxt.step = st_r.cfg[4] ? 5'(sacc_pkg::SAMPLE_LONG) : 5'(sacc_pkg::SAMPLE_SHORT);
			end
		end
		// Channels 26 and 27, 20 and 21 come through the decoder as plain mux lines.
		st_nxt.irq = st_nxt.done && st_nxt.sc1[sacc_pkg::SC1_IEN_BIT];
	end

	// Register all state.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			st_r <= '0;
			st_r.sc1 <= sacc_pkg::RESET_SC1;
			st_r.state <= sacc_pkg::SACC_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign reg_rdata = st_r.rdata;
	assign mux_sel = st_r.mux;
	assign pin_analog = st_r.pin_a;
	assign dac_bit_set = st_r.dac;
	assign sample_on = st_r.samp;
	assign conv_irq = st_r.irq;
	// The alternate clock input is tied low because nothing drives it in this part.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			alternate_clock_input <= 1'b0;
		end else begin
			alternate_clock_input <= 1'b0;
		end
	end

	// Assertions.
	sequence s_wr_start;
		wr_sc1 && reg_wdata[4:0] != sacc_pkg::CH_OFF;
	endsequence
	a_abort_restart: assert property (@(posedge core_clk) disable iff (reset)
		s_wr_start |=> st_r.state == sacc_pkg::SACC_SAMPLE && !st_r.done)
		else $error("write did not restart conversion");
	a_off_code_stops: assert property (@(posedge core_clk) disable iff (reset)
		wr_sc1 && reg_wdata[4:0] == sacc_pkg::CH_OFF |=> st_r.state == sacc_pkg::SACC_IDLE)
		else $error("all ones channel did not stop");
	a_done_clear_lo: assert property (@(posedge core_clk) disable iff (reset)
		reg_rd && reg_addr == sacc_pkg::OFF_RES_LO && !(st_r.state == sacc_pkg::SACC_CONVERT && tick)
		|=> !st_r.done)
		else $error("done flag not cleared by low read");
	a_irq_follows: assert property (@(posedge core_clk) disable iff (reset)
		conv_irq == (st_r.done && st_r.sc1[sacc_pkg::SC1_IEN_BIT]))
		else $error("interrupt does not follow flag");
	a_alt_low: assert property (@(posedge core_clk) disable iff (reset)
		!alternate_clock_input && st_r.cfg[1:0] != sacc_pkg::CLK_ALT)
		else $error("alternate clock in use");
	a_no_self_start: assert property (@(posedge core_clk) disable iff (reset)
		st_r.state == sacc_pkg::SACC_IDLE && !wr_sc1 |=> st_r.state == sacc_pkg::SACC_IDLE)
		else $error("conversion started without software");
	a_stop_hold: assert property (@(posedge core_clk) disable iff (reset)
		!run_ok && !wr_sc1 |=> $stable(st_r.sar))
		else $error("converted in stop without enables");
	a_eight_bit: assert property (@(posedge core_clk) disable iff (reset)
		!ten_bit && $changed(st_r.result) |-> st_r.result[9:8] == 2'b00)
		else $error("8-bit result not right justified");
	a_pin_route: assert property (@(posedge core_clk) disable iff (reset)
		reg_wr && reg_addr == sacc_pkg::OFF_PIN |-> ##2 pin_analog == $past(reg_wdata, 2))
		else $error("pin routing mismatch");
endmodule
